// ===== include/buck_seq_pkg.sv
// Operation
// - Mode pin at ground runs forced-PWM, one switching cycle every period tick.
// - Forced-PWM switching starts only after a short settling time following enable rise.
// - First switching action in either mode turns the low-side switch on.
// - Low-side switch stays on through period end and turns off only on sink-current threshold.
// - After early low-side off, high-side stays on until current level or period end.
// - Sink threshold rises in four steps, reaching full limit after 128 periods.
// - Mode pin open or mid-supply selects monotonic startup into a prebiased output.
// - Monotonic mode holds both switches off until feedback crosses soft-start voltage.
// - Monotonic mode also ramps the sink threshold in four steps over 128 periods.
// - Monotonic mode becomes forced-PWM 4096 periods after feedback first passes 92.5%.
// - Enable low shuts down with both switches off; enable high restarts startup.
package buck_seq_pkg;

	localparam int CLK_PERIOD_NS = 40;
	localparam int SETTLE_TIME_NS = 2000;
	localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W = 8;
	localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYCLES - 1);

	localparam int RAMP_PERIODS_DEF = 128;
	localparam int HANDOVER_PERIODS_DEF = 4096;
	localparam int SINK_STEPS = 4;
	localparam int STEP_W = 3;
	localparam logic [STEP_W-1:0] SINK_STEP_FIRST = 3'h0;
	localparam logic [STEP_W-1:0] SINK_STEP_FULL = 3'h4;

	// three-level strap as seen by the pin comparator
	localparam logic [1:0] MODE_STRAP_GND = 2'h0;
	localparam logic [1:0] MODE_STRAP_MID = 2'h1;
	localparam logic [1:0] MODE_STRAP_VDD = 2'h2;

	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_SETTLE = 2'b01,
		ST_WAIT_FB = 2'b10,
		ST_RUN = 2'b11
	} seq_state_t;

	typedef struct packed {
		logic fb_above_ss;
		logic fb_above_good;
		logic ls_sink_hit;
		logic hs_cur_hit;
	} compare_t;

	typedef struct packed {
		logic ls_on;
		logic hs_on;
	} switch_t;

endpackage : buck_seq_pkg

// ===== verilog/period_counter.sv
`timescale 1ns/100ps
// saturating count of switching periods
module period_counter #(
	parameter int LIMIT = 128,
	parameter int W = 8
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic clear_i,
	input wire logic tick_i,
	output logic [W-1:0] count_o,
	output logic done_o
);

	localparam logic [W-1:0] LIMIT_V = W'(LIMIT);

	generate
		if (LIMIT < 1 || LIMIT >= (1 << W)) begin : g_bad
			$error("period_counter: LIMIT does not fit W");
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (srst_i || clear_i) begin
			count_o <= '0;
		end else if (tick_i && count_o != LIMIT_V) begin
			count_o <= count_o + W'(1);
		end
	end

	assign done_o = (count_o == LIMIT_V);

endmodule : period_counter

// ===== verilog/buck_startup_mode_sequencer.sv
`timescale 1ns/100ps
module buck_startup_mode_sequencer
	import buck_seq_pkg::*;
#(
	parameter int RAMP_PERIODS = RAMP_PERIODS_DEF,
	parameter int HANDOVER_PERIODS = HANDOVER_PERIODS_DEF
) (
	input wire logic CLK_I,
	input wire logic SRST_I,
	input wire logic EN_I,
	input wire logic [1:0] MODE_I,
	input wire logic PERIOD_TICK_I,
	input wire compare_t COMPARE_I,
	output logic LS_ON_O,
	output logic HS_ON_O,
	output logic [STEP_W-1:0] SINK_STEP_O,
	output logic MODE_PWM_O,
	output logic SWITCHING_O
);

	localparam int RAMP_W = $clog2(RAMP_PERIODS + 1);
	localparam int HO_W = $clog2(HANDOVER_PERIODS + 1);
	localparam int STEP_LEN = RAMP_PERIODS / SINK_STEPS;

	generate
		if (RAMP_PERIODS < SINK_STEPS || (RAMP_PERIODS % SINK_STEPS) != 0) begin : g_bad_ramp
			$error("RAMP_PERIODS must be a nonzero multiple of the step count");
		end
		if (HANDOVER_PERIODS < 1) begin : g_bad_ho
			$error("HANDOVER_PERIODS must be at least one");
		end
	endgenerate

	function automatic logic [STEP_W-1:0] step_of(input logic [RAMP_W-1:0] n, input logic full);
		logic [RAMP_W-1:0] q;
		q = RAMP_W'(n / RAMP_W'(STEP_LEN));
		step_of = full ? SINK_STEP_FULL : STEP_W'(q);
	endfunction : step_of

	seq_state_t state_r;
	logic [SETTLE_W-1:0] settle_r;
	logic mode_forced_r;
	logic started_r;
	logic armed_r;
	switch_t sw_r;
	logic [RAMP_W-1:0] ramp_cnt;
	logic ramp_done;
	logic ho_done;
	logic run_tick;

	assign run_tick = EN_I && state_r == ST_RUN && PERIOD_TICK_I;

	////////////////////////////////////////////////////////////////////////////////
	// startup sequence

	always_ff @(posedge CLK_I) begin
		if (SRST_I || !EN_I) begin
			state_r <= ST_OFF;
		end else begin
			case (state_r)
				ST_OFF: state_r <= ST_SETTLE;
				ST_SETTLE: begin
					if (settle_r == SETTLE_LAST) begin
						state_r <= mode_forced_r ? ST_RUN : ST_WAIT_FB;
					end
				end
				ST_WAIT_FB: begin
					if (COMPARE_I.fb_above_ss) begin
						state_r <= ST_RUN;
					end
				end
				ST_RUN: state_r <= ST_RUN;
				default: state_r <= ST_OFF;
			endcase
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I || state_r != ST_SETTLE) begin
			settle_r <= '0;
		end else if (settle_r != SETTLE_LAST) begin
			settle_r <= settle_r + SETTLE_W'(1);
		end
	end

	// strap caught while shut down, held for the whole run
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			mode_forced_r <= 1'b0;
		end else if (state_r == ST_OFF) begin
			mode_forced_r <= (MODE_I == MODE_STRAP_GND);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// per-period switch control

	always_ff @(posedge CLK_I) begin
		if (SRST_I || !EN_I || state_r != ST_RUN) begin
			sw_r <= '0;
		end else if (PERIOD_TICK_I) begin
			sw_r <= '{ls_on: 1'b1, hs_on: 1'b0};
		end else if (sw_r.ls_on && COMPARE_I.ls_sink_hit) begin
			sw_r <= '{ls_on: 1'b0, hs_on: 1'b1};
		end else if (sw_r.hs_on && COMPARE_I.hs_cur_hit) begin
			sw_r.hs_on <= 1'b0;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I || !EN_I || state_r != ST_RUN) begin
			started_r <= 1'b0;
		end else if (PERIOD_TICK_I) begin
			started_r <= 1'b1;
		end
	end

	assign LS_ON_O = sw_r.ls_on;
	assign HS_ON_O = sw_r.hs_on;
	assign SWITCHING_O = started_r;

	////////////////////////////////////////////////////////////////////////////////
	// sink threshold ramp, counted in switching periods

	period_counter #(
		.LIMIT(RAMP_PERIODS),
		.W(RAMP_W)
	) u_ramp (
		.clk_i(CLK_I),
		.srst_i(SRST_I),
		.clear_i(!started_r && !run_tick),
		.tick_i(started_r && run_tick),
		.count_o(ramp_cnt),
		.done_o(ramp_done)
	);

	always_ff @(posedge CLK_I) begin
		if (SRST_I || !started_r) begin
			SINK_STEP_O <= SINK_STEP_FIRST;
		end else begin
			SINK_STEP_O <= step_of(ramp_cnt, ramp_done);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// monotonic to forced-PWM hand-over

	always_ff @(posedge CLK_I) begin
		if (SRST_I || !EN_I || state_r != ST_RUN) begin
			armed_r <= 1'b0;
		end else if (COMPARE_I.fb_above_good) begin
			armed_r <= 1'b1;
		end
	end

	period_counter #(
		.LIMIT(HANDOVER_PERIODS),
		.W(HO_W)
	) u_handover (
		.clk_i(CLK_I),
		.srst_i(SRST_I),
		.clear_i(!armed_r),
		.tick_i(run_tick),
		.count_o(),
		.done_o(ho_done)
	);

	always_ff @(posedge CLK_I) begin
		if (SRST_I || state_r == ST_OFF) begin
			MODE_PWM_O <= 1'b0;
		end else if (state_r == ST_SETTLE) begin
			MODE_PWM_O <= mode_forced_r;
		end else if (ho_done && armed_r) begin
			MODE_PWM_O <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (SRST_I);

	a_shutdown_off: assert property (!EN_I |=> !LS_ON_O && !HS_ON_O)
		else $error("switch on after enable low");
	a_never_both: assert property (!(LS_ON_O && HS_ON_O))
		else $error("both switches on");
	a_low_side_first: assert property (!started_r |-> !HS_ON_O)
		else $error("high side before first low side");
	a_monotonic_hold: assert property (state_r == ST_WAIT_FB |-> !LS_ON_O && !HS_ON_O)
		else $error("switching before feedback crossed soft-start");
	a_sink_turnoff: assert property (EN_I && LS_ON_O && COMPARE_I.ls_sink_hit
		&& !PERIOD_TICK_I |=> !LS_ON_O && HS_ON_O)
		else $error("low side not handed to high side on sink limit");
	a_period_start: assert property (run_tick |=> LS_ON_O && !HS_ON_O)
		else $error("period start did not turn low side on");
	a_hs_end: assert property (EN_I && HS_ON_O && COMPARE_I.hs_cur_hit
		&& !PERIOD_TICK_I |=> !HS_ON_O)
		else $error("high side stayed on past current level");
	a_ramp_full: assert property (started_r && $rose(ramp_done)
		|=> SINK_STEP_O == SINK_STEP_FULL)
		else $error("sink threshold not full after ramp");
	a_settle_hold: assert property (EN_I && state_r == ST_SETTLE
		&& settle_r != SETTLE_LAST |=> state_r == ST_SETTLE)
		else $error("settling interval cut short");
	a_handover_set: assert property (EN_I && state_r == ST_RUN && armed_r && ho_done
		|=> MODE_PWM_O)
		else $error("no hand-over to forced-PWM");

	c_forced_run: cover property (mode_forced_r && run_tick);
	c_sink_early: cover property (LS_ON_O && COMPARE_I.ls_sink_hit ##1 HS_ON_O);
	c_monotonic_handover: cover property (!mode_forced_r ##1 $rose(MODE_PWM_O));

endmodule : buck_startup_mode_sequencer

// ===== bench/stage_model.sv
`timescale 1ns/100ps
module stage_model
	import buck_seq_pkg::*;
(
	input wire logic clk_i,
	input wire logic ls_i,
	input wire logic hs_i,
	input wire logic fb_ss_i,
	input wire logic fb_good_i,
	input wire logic [2:0] sink_i,
	output logic tick_o,
	output compare_t cmp_o
);
	logic [2:0] ph_r = 3'h0;
	////////////////////////////////////////////////////////////////
	// oscillator: one tick every eight cycles
	always @(negedge clk_i) begin
		ph_r <= ph_r + 3'h1;
		tick_o <= (ph_r == 3'h6);
		cmp_o.ls_sink_hit <= ls_i && ph_r >= sink_i && ph_r < 3'h6;
		cmp_o.hs_cur_hit <= hs_i && ph_r >= sink_i + 3'h3 && ph_r < 3'h7;
		cmp_o.fb_above_ss <= fb_ss_i;
		cmp_o.fb_above_good <= fb_good_i;
	end
endmodule : stage_model

// ===== bench/buck_startup_mode_sequencer_bench.sv
`timescale 1ns/100ps
module buck_startup_mode_sequencer_bench;
	import buck_seq_pkg::*;
	localparam int RAMP = 8;
	localparam int HAND = 16;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic en = 1'b0;
	logic [1:0] mode = 2'h0;
	logic fb_ss = 1'b0;
	logic fb_good = 1'b0;
	logic [2:0] sink = 3'h1;
	logic tick, ls, hs, pwm, sw, seen, exp_hit;
	compare_t cmp;
	logic [STEP_W-1:0] step;
	int mismatches = 0;
	int compares = 0;
	int n;
	initial begin
		forever #20 clk = ~clk;
	end
	stage_model stage_model_inst (.clk_i(clk), .ls_i(ls), .hs_i(hs), .fb_ss_i(fb_ss),
		.fb_good_i(fb_good), .sink_i(sink), .tick_o(tick), .cmp_o(cmp));
	buck_startup_mode_sequencer #(.RAMP_PERIODS(RAMP), .HANDOVER_PERIODS(HAND))
		buck_startup_mode_sequencer_inst (.CLK_I(clk), .SRST_I(srst), .EN_I(en),
		.MODE_I(mode), .PERIOD_TICK_I(tick), .COMPARE_I(cmp), .LS_ON_O(ls), .HS_ON_O(hs),
		.SINK_STEP_O(step), .MODE_PWM_O(pwm), .SWITCHING_O(sw));
	////////////////////////////////////////////////////////////////
	task chk(input string what, input logic [3:0] exp, input logic [3:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task report_and_stop;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop
	// sel 0 low side on, 1 period tick
	task wait_on(input int sel, input int lim);
		n = 0;
		while (!((sel == 0 && ls === 1'b1) || (sel == 1 && tick === 1'b1))) begin
			@(negedge clk);
			n++;
			if (n > lim) begin
				mismatches++;
				$display("[ERR] wait %0d expected within %0d seen %0d", sel, lim, n);
				report_and_stop();
			end
		end
	endtask : wait_on
	task periods(input int cnt);
		repeat (cnt) begin
			wait_on(1, 20);
			exp_hit = (sink < 3'h6);
			chk("ls at tick", 4'h1, ls);
			seen = 1'b0;
			repeat (7) begin
				@(negedge clk);
				chk("overlap", 4'h0, ls & hs);
				seen = seen | (hs & ~ls);
			end
			chk("hs after early ls off", {3'h0, exp_hit}, seen);
			chk("ls off on sink hit", {3'h0, !exp_hit}, ls);
		end
	endtask : periods
	// four equal steps, full limit once RAMP ticks follow the first
	function automatic logic [3:0] exp_step(input int k);
		if (k >= RAMP) begin
			return 4'(SINK_STEP_FULL);
		end
		return 4'(k / (RAMP / SINK_STEPS));
	endfunction : exp_step
	task ramp_walk;
		for (int i = 0; i < RAMP + 2; i++) begin
			periods(1);
			chk("ramp step", exp_step(i), step);
		end
	endtask : ramp_walk
	task start(input logic [1:0] m);
		mode = m;
		sink <= 3'(1 + $urandom % 3);
		en = 1'b0;
		repeat (2) @(negedge clk);
		chk("shutdown ls", 4'h0, ls);
		chk("shutdown hs", 4'h0, hs);
		en = 1'b1;
	endtask : start
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(19009));
		repeat (16) @(negedge clk);
		srst = 1'b0;
		chk("reset pwm", 4'h0, pwm);
		start(MODE_STRAP_GND);
		wait_on(0, 200);
		chk("settle", 4'h1, n >= SETTLE_CYCLES);
		chk("ls first", 4'h0, hs);
		chk("forced", 4'h1, pwm);
		chk("switching on", 4'h1, sw);
		chk("ramp start", SINK_STEP_FIRST, step);
		ramp_walk();
		chk("ramp full", SINK_STEP_FULL, step);
		// corner: sink limit never reached, low side runs to period end
		sink <= 3'h7;
		periods(2);
		for (int m = 1; m <= 2; m++) begin
			fb_ss <= 1'b0;
			fb_good <= 1'b0;
			start(2'(m));
			seen = 1'b0;
			repeat (150) @(negedge clk) seen = seen | ls | hs;
			chk("held off", 4'h0, seen);
			chk("no switching", 4'h0, sw);
			fb_ss <= 1'b1;
			wait_on(0, 40);
			chk("mono ls first", 4'h0, hs);
			chk("mono switching", 4'h1, sw);
			chk("mono mode", 4'h0, pwm);
			chk("mono ramp start", SINK_STEP_FIRST, step);
			fb_good <= 1'b1;
			ramp_walk();
			chk("mono ramp full", SINK_STEP_FULL, step);
			periods(HAND - RAMP - 4);
			chk("early handover", 4'h0, pwm);
			periods(2);
			chk("handover not yet", 4'h0, pwm);
			periods(1);
			chk("handover", 4'h1, pwm);
		end
		report_and_stop();
	end
endmodule : buck_startup_mode_sequencer_bench
